// file: core/pth_regs.sv
// Proximity threshold register bank with per-channel event compare.
// Assumes the serial interface core presents byte reads and writes
// as one-cycle strobes, and the sequencer pulses meas_valid_i.
`timescale 1ns/1ps
module pth_regs
  import pth_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [7:0] reg_rdata_o,
  input wire logic auto_run_i,
  input wire logic legacy_fmt_i,
  input wire logic below_mode_i,
  input wire logic meas_valid_i,
  input wire logic meas_chan_i,
  input wire logic [15:0] meas_data_i,
  output logic prox1_event_o,
  output logic prox2_event_o
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] p1_lo;
    logic [7:0] p1_hi;
    logic [7:0] p2_lo;
    logic [7:0] p2_hi;
    logic [7:0] rdata;
  } pth_regs_s;

  // Registered copy and its next value
  pth_regs_s st_q;
  pth_regs_s st_d;
  logic [15:0] thr1;
  logic [15:0] thr2;
  logic run_meas;

  pth_cmp_if c1_if ();
  pth_cmp_if c2_if ();

  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------
  // Writes land byte by byte; reads return the stored byte next cycle
  // Writing and reading one address in one cycle returns the old byte
  always_comb begin
    st_d = st_q;
    if (reg_we_i) begin
      if (reg_addr_i == ADDR_P1_LO) begin
        st_d.p1_lo = reg_wdata_i;
      end else if (reg_addr_i == ADDR_P1_HI) begin
        st_d.p1_hi = reg_wdata_i;
      end else if (reg_addr_i == ADDR_P2_LO) begin
        st_d.p2_lo = reg_wdata_i;
      end else if (reg_addr_i == ADDR_P2_HI) begin
        st_d.p2_hi = reg_wdata_i;
      end
    end
    if (reg_re_i) begin
      if (reg_addr_i == ADDR_P1_LO) begin
        st_d.rdata = st_q.p1_lo;
      end else if (reg_addr_i == ADDR_P1_HI) begin
        st_d.rdata = st_q.p1_hi;
      end else if (reg_addr_i == ADDR_P2_LO) begin
        st_d.rdata = st_q.p2_lo;
      end else if (reg_addr_i == ADDR_P2_HI) begin
        st_d.rdata = st_q.p2_hi;
      end else begin
        st_d.rdata = RD_UNMAPPED;
      end
    end
  end

  // State register, low bytes clear at reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q.p1_lo <= RST_LO;
      st_q.p1_hi <= RST_HI;
      st_q.p2_lo <= RST_LO;
      st_q.p2_hi <= RST_HI;
      st_q.rdata <= RD_UNMAPPED;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata_o = st_q.rdata;

  // ----------------------------------------------------------------
  // Threshold compare
  // ----------------------------------------------------------------
  // Live byte values feed the compare, so a half-written pair is seen as is
  // Hosts pause measurement around threshold rewrites, or discard results
  assign thr1 = legacy_fmt_i ? pth_expand(st_q.p1_lo) : {st_q.p1_hi, st_q.p1_lo};
  assign thr2 = legacy_fmt_i ? pth_expand(st_q.p2_lo) : {st_q.p2_hi, st_q.p2_lo};
  assign run_meas = meas_valid_i && auto_run_i;

  // Route each finished measurement to its own channel comparator
  assign c1_if.thresh = thr1;
  assign c1_if.meas = meas_data_i;
  assign c1_if.below = below_mode_i;
  assign c1_if.fire = run_meas && !meas_chan_i;
  assign c2_if.thresh = thr2;
  assign c2_if.meas = meas_data_i;
  assign c2_if.below = below_mode_i;
  assign c2_if.fire = run_meas && meas_chan_i;

  // One comparator per channel, each with its own event flop
  pth_cmp u_cmp1 (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .cif(c1_if.cmp)
  );

  pth_cmp u_cmp2 (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .cif(c2_if.cmp)
  );

  // Events come straight from the comparator flops
  assign prox1_event_o = c1_if.hit;
  assign prox2_event_o = c2_if.hit;

  // ----------------------------------------------------------------
  // Compare checks
  // ----------------------------------------------------------------
  // Every check runs on the block clock and rests while reset is held
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // Register port steps: a write strobe, then a read strobe
  sequence wr_p1_hi_s;
    reg_we_i && !reg_re_i && reg_addr_i == ADDR_P1_HI;
  endsequence
  sequence rd_p1_hi_s;
    reg_re_i && !reg_we_i && reg_addr_i == ADDR_P1_HI;
  endsequence
  sequence wr_p1_lo_s;
    reg_we_i && reg_addr_i == ADDR_P1_LO;
  endsequence

  // Events in both crossing senses with the full 16-bit thresholds
  ch1_above_a: assert property (run_meas && !meas_chan_i && !legacy_fmt_i && !below_mode_i
      && meas_data_i > {st_q.p1_hi, st_q.p1_lo} |=> prox1_event_o)
    else $error("channel one event missing above threshold");
  ch1_below_a: assert property (run_meas && !meas_chan_i && !legacy_fmt_i && below_mode_i
      && meas_data_i < {st_q.p1_hi, st_q.p1_lo} |=> prox1_event_o && !prox2_event_o)
    else $error("channel one event missing below threshold");
  ch2_above_a: assert property (run_meas && meas_chan_i && !legacy_fmt_i && !below_mode_i
      && meas_data_i > {st_q.p2_hi, st_q.p2_lo} |=> prox2_event_o)
    else $error("channel two event missing above threshold");
  ch2_below_a: assert property (run_meas && meas_chan_i && !legacy_fmt_i && below_mode_i
      && meas_data_i < {st_q.p2_hi, st_q.p2_lo} |=> prox2_event_o && !prox1_event_o)
    else $error("channel two event missing below threshold");

  // Each event comes only from a measurement of its own channel
  ch1_event_src_a: assert property (prox1_event_o |-> $past(run_meas && !meas_chan_i))
    else $error("channel one event without its measurement");
  ch2_event_src_a: assert property (prox2_event_o |-> $past(run_meas && meas_chan_i))
    else $error("channel two event without its measurement");

  // A lone low-byte write reaches the compare at once, beside the old high byte
  byte_split_a: assert property (reg_we_i && reg_addr_i == ADDR_P1_LO
      |=> st_q.p1_lo == $past(reg_wdata_i) && st_q.p1_hi == $past(st_q.p1_hi))
    else $error("low byte write disturbed high byte");
  mixed_pair_a: assert property (wr_p1_lo_s ##1 !legacy_fmt_i
      |-> thr1 == {st_q.p1_hi, $past(reg_wdata_i)})
    else $error("compare did not see the new low byte");

  // Compressed format: threshold expanded from the low byte alone
  legacy_fmt_a: assert property (run_meas && !meas_chan_i && legacy_fmt_i && !below_mode_i
      && meas_data_i <= pth_expand(st_q.p1_lo) |=> !prox1_event_o)
    else $error("legacy threshold ignored");
  legacy_ch2_a: assert property (run_meas && meas_chan_i && legacy_fmt_i && !below_mode_i
      && meas_data_i > pth_expand(st_q.p2_lo) |=> prox2_event_o)
    else $error("legacy channel two threshold ignored");

  // ----------------------------------------------------------------
  // Register checks
  // ----------------------------------------------------------------
  // Writes land in the addressed byte only; reads give the byte held before the edge
  p1_readback_a: assert property (wr_p1_hi_s ##1 rd_p1_hi_s
      |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("high byte read back wrong");
  p1_high_a: assert property (reg_we_i && reg_addr_i == ADDR_P1_HI
      |=> st_q.p1_hi == $past(reg_wdata_i) && st_q.p1_lo == $past(st_q.p1_lo))
    else $error("channel one high byte not stored");
  rd_p1_lo_a: assert property (reg_re_i && reg_addr_i == ADDR_P1_LO
      |=> reg_rdata_o == $past(st_q.p1_lo))
    else $error("channel one low byte read back wrong");
  low_reset_a: assert property ($past(!rst_n_i) |-> st_q.p1_lo == RST_LO
      && st_q.p2_lo == RST_LO)
    else $error("low bytes not zero after reset");
  p2_low_a: assert property (reg_we_i && reg_addr_i == ADDR_P2_LO
      |=> st_q.p2_lo == $past(reg_wdata_i))
    else $error("channel two low byte not stored");
  rd_p2_lo_a: assert property (reg_re_i && reg_addr_i == ADDR_P2_LO
      |=> reg_rdata_o == $past(st_q.p2_lo))
    else $error("channel two low byte read back wrong");
  p2_high_a: assert property (reg_we_i && reg_addr_i == ADDR_P2_HI
      |=> st_q.p2_hi == $past(reg_wdata_i))
    else $error("channel two high byte not stored");
  rd_p2_hi_a: assert property (reg_re_i && reg_addr_i == ADDR_P2_HI
      |=> reg_rdata_o == $past(st_q.p2_hi))
    else $error("channel two high byte read back wrong");

  // Unmapped reads give the filler byte; read data holds between reads
  unmapped_rd_a: assert property (reg_re_i && reg_addr_i != ADDR_P1_LO
      && reg_addr_i != ADDR_P1_HI && reg_addr_i != ADDR_P2_LO && reg_addr_i != ADDR_P2_HI
      |=> reg_rdata_o == RD_UNMAPPED)
    else $error("unmapped read did not give the filler byte");
  rd_hold_a: assert property (!reg_re_i |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");

  // Measurements taken while paused raise nothing
  no_meas_a: assert property (!run_meas |=> !prox1_event_o && !prox2_event_o)
    else $error("event without measurement");
endmodule : pth_regs

// file: core/pth_pkg.sv
// Constants and helpers for the proximity threshold register bank.
// Assumes a byte-wide register port driven by the serial interface core.
// What this block does
// - Hold 16-bit channel one threshold; compare each channel one measurement made while auto_run_i is high for host event.
// - Hold separate 16-bit channel two threshold; compare channel two measurements likewise.
// - Threshold bytes update separately; a comparison may see a mixed old/new value.
// - Legacy format: one 8-bit compressed threshold at each channel's low-byte address.
// - Channel one bits 7:0 at 0x11, bits 15:8 at 0x12, both read-write.
// - Low-byte registers reset to zero; channel two low byte sits at 0x13.
// - Channel two bits 15:8 held in read-write register at 0x14.
package pth_pkg;
  localparam int TH_W = 16;
  localparam logic [7:0] ADDR_P1_LO = 8'h11;
  localparam logic [7:0] ADDR_P1_HI = 8'h12;
  localparam logic [7:0] ADDR_P2_LO = 8'h13;
  localparam logic [7:0] ADDR_P2_HI = 8'h14;
  localparam logic [7:0] RST_LO = 8'h00;
  localparam logic [7:0] RST_HI = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // Expands a compressed byte: upper nibble exponent, lower nibble mantissa
  function automatic logic [15:0] pth_expand(input logic [7:0] c);
    logic [15:0] v;
    v = {11'h000, 1'b1, c[3:0]};
    if (c == 8'h00) begin
      pth_expand = 16'h0000;
    end else if (c[7:4] > 4'hb) begin
      pth_expand = 16'hffff;
    end else begin
      pth_expand = v << c[7:4];
    end
  endfunction : pth_expand
endpackage : pth_pkg

// file: core/pth_cmp_if.sv
// Carrier between the register bank and one channel comparator.
// Assumes both ends share the block clock.
`timescale 1ns/1ps
interface pth_cmp_if;
  logic [15:0] thresh;
  logic [15:0] meas;
  logic fire;
  logic below;
  logic hit;
  modport src (output thresh, output meas, output fire, output below, input hit);
  modport cmp (input thresh, input meas, input fire, input below, output hit);
endinterface : pth_cmp_if

// file: core/pth_cmp.sv
// One-channel unsigned threshold comparator with registered event.
// Assumes fire is a one-cycle pulse per completed measurement.
`timescale 1ns/1ps
module pth_cmp
  import pth_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  pth_cmp_if.cmp cif
);
  typedef struct packed {
    logic hit;
  } pth_cmp_s;

  pth_cmp_s st_q;
  pth_cmp_s st_d;

  // Event when the measurement crosses the threshold in the chosen sense
  always_comb begin
    st_d = st_q;
    st_d.hit = 1'b0;
    if (cif.fire) begin
      st_d.hit = cif.below ? (cif.meas < cif.thresh) : (cif.meas > cif.thresh);
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign cif.hit = st_q.hit;
endmodule : pth_cmp

// file: verif/pth_host.sv
// Host model: byte register writes and reads, run control.
// Assumes the bank answers reads at the edge that samples the strobe.
`timescale 1ns/1ps
module pth_host (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic we_o,
  output logic re_o,
  output logic run_o
);
  // Idle bus at time zero
  initial begin
    {addr_o, wdata_o, we_o, re_o, run_o} = '0;
  end
  // Byte write with measurement stopped around it; an idle edge follows
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic r;
    r = run_o;
    run_o = 1'b0;
    addr_o = a;
    wdata_o = d;
    we_o = 1'b1;
    @(posedge clk_i);
    #1 we_o = 1'b0;
    wdata_o = ~d; // Released data no longer shows the byte
    run_o = r;
    @(posedge clk_i);
    #1;
  endtask : wr
  // Byte read, data taken after the answer edge; an idle edge follows
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr_o = a;
    re_o = 1'b1;
    @(posedge clk_i);
    #1 re_o = 1'b0;
    d = rdata_i;
    @(posedge clk_i);
    #1;
  endtask : rd
  // Write then read of one address on adjacent edges
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    logic r;
    r = run_o;
    run_o = 1'b0;
    addr_o = a;
    wdata_o = d;
    we_o = 1'b1;
    @(posedge clk_i);
    #1 we_o = 1'b0;
    re_o = 1'b1;
    wdata_o = ~d;
    @(posedge clk_i);
    #1 re_o = 1'b0;
    q = rdata_i;
    run_o = r;
    @(posedge clk_i);
    #1;
  endtask : wr_rd
  // Autonomous run on or off
  task automatic run(input logic r);
    run_o = r;
  endtask : run
endmodule : pth_host

// file: verif/pth_regs_tb.sv
// Self-checking bench for the threshold register bank.
// Assumes the host model drives the register port one ns after edges.
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; \
  $display("ERROR %0t got %h want %h", $time, a, b); end end
module pth_regs_tb;
  import pth_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, leg = 1'b0, blw = 1'b0, mv = 1'b0, mc = 1'b0;
  logic [15:0] md = 16'h0000;
  logic [7:0] ad, wd, rdat;
  logic we, re, run, p1, p2;
  int miscompares = 0, checks_done = 0;
  always #25 clk = ~clk;
  pth_host i_pth_host (.clk_i(clk), .rdata_i(rdat), .addr_o(ad), .wdata_o(wd),
    .we_o(we), .re_o(re), .run_o(run));
  pth_regs i_pth_regs (.clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(ad), .reg_wdata_i(wd),
    .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdat), .auto_run_i(run),
    .legacy_fmt_i(leg), .below_mode_i(blw), .meas_valid_i(mv), .meas_chan_i(mc),
    .meas_data_i(md), .prox1_event_o(p1), .prox2_event_o(p2));
  // Read one byte and compare
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_pth_host.rd(a, d);
    `CHK(d, e)
  endtask : rc
  // One measurement; events judged in the following cycle
  task automatic ms(input logic c, input logic [15:0] v, input logic e1, input logic e2);
    mv = 1'b1;
    mc = c;
    md = v;
    @(posedge clk);
    #1 mv = 1'b0;
    md = ~v;
    `CHK(p1, e1)
    `CHK(p2, e2)
    @(posedge clk);
    #1;
  endtask : ms
  task automatic t_reset;
    rc(8'h11, 8'h00);
    rc(8'h12, 8'h00);
    rc(8'h13, 8'h00);
    rc(8'h14, 8'h00);
    rc(8'h20, 8'h00);
    $display("test reset done");
  endtask : t_reset
  task automatic t_regs;
    logic [7:0] d;
    i_pth_host.wr(8'h11, 8'ha5);
    i_pth_host.wr(8'h12, 8'h3c);
    i_pth_host.wr(8'h13, 8'h5a);
    i_pth_host.wr(8'h14, 8'hc3);
    i_pth_host.wr(8'h20, 8'hff);
    rc(8'h11, 8'ha5);
    rc(8'h12, 8'h3c);
    rc(8'h13, 8'h5a);
    rc(8'h14, 8'hc3);
    i_pth_host.wr_rd(8'h12, 8'h6d, d);
    `CHK(d, 8'h6d)
    rc(8'h20, 8'h00);
    $display("test regs done");
  endtask : t_regs
  task automatic t_ch1;
    i_pth_host.wr(8'h11, 8'h34);
    i_pth_host.wr(8'h12, 8'h12);
    i_pth_host.run(1'b1);
    ms(1'b0, 16'h1235, 1'b1, 1'b0);
    ms(1'b0, 16'h1234, 1'b0, 1'b0);
    blw = 1'b1;
    ms(1'b0, 16'h1233, 1'b1, 1'b0);
    blw = 1'b0;
    i_pth_host.run(1'b0);
    ms(1'b0, 16'hffff, 1'b0, 1'b0);
    $display("test channel one done");
  endtask : t_ch1
  task automatic t_ch2;
    i_pth_host.wr(8'h13, 8'h78);
    i_pth_host.wr(8'h14, 8'h56);
    i_pth_host.run(1'b1);
    ms(1'b1, 16'h5679, 1'b0, 1'b1);
    ms(1'b1, 16'h5678, 1'b0, 1'b0);
    blw = 1'b1;
    ms(1'b1, 16'h5677, 1'b0, 1'b1);
    blw = 1'b0;
    ms(1'b0, 16'h0001, 1'b0, 1'b0);
    $display("test channel two done");
  endtask : t_ch2
  task automatic t_mixed;
    i_pth_host.wr(8'h11, 8'h00); // Only the low byte is replaced
    ms(1'b0, 16'h1201, 1'b1, 1'b0);
    $display("test mixed done");
  endtask : t_mixed
  task automatic t_legacy;
    leg = 1'b1;
    i_pth_host.wr(8'h11, 8'h23);
    ms(1'b0, 16'h004d, 1'b1, 1'b0);
    ms(1'b0, 16'h004c, 1'b0, 1'b0);
    i_pth_host.wr(8'h13, 8'h23);
    ms(1'b1, 16'h004d, 1'b0, 1'b1);
    leg = 1'b0;
    $display("test legacy done");
  endtask : t_legacy
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    print_verdict();
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    @(posedge clk);
    #1;
    t_reset();
    t_regs();
    t_ch1();
    t_ch2();
    t_mixed();
    t_legacy();
    print_verdict();
  end
endmodule : pth_regs_tb
